// *** rtl/fhs_regs.svh ***
`ifndef FHS_REGS_SVH
`define FHS_REGS_SVH
`define FHS_ADDR_STATUS 12'h3f4
`define FHS_ADDR_RATE_SEL 12'h3f4
`define FHS_ADDR_DATA 12'h3f5
`define FHS_ADDR_INPUT 12'h3f7
`define FHS_ADDR_RATE_SHADOW 12'h01f
`define FHS_ADDR_FORCE_CHG 12'h01e
`define FHS_ADDR_CTRL 12'h020
`define FHS_ADDR_ENGINE 12'h021
`define FHS_RATE_SEL_RESET 8'h02
`define FHS_RATE_SEL_SWRST_BIT 7
`define FHS_RATE_SEL_PRECOMP_LSB 2
`define FHS_ST_REQ_BIT 7
`define FHS_ST_DIR_BIT 6
`define FHS_ST_BUSY_BIT 4
`define FHS_ST_SEEK_BIT 0
`define FHS_CTRL_ALT_BIT 0
`define FHS_CTRL_KIND_LSB 1
`define FHS_CTRL_RTYPE_LSB 3
`define FHS_CTRL_FIFO_EN_BIT 5
`define FHS_FORCE_EN_BIT 1
`define FHS_FORCE_VAL_BIT 0
`define FHS_PRECOMP_2M_PS 17'd20800
`define FHS_PRECOMP_1M_PS 17'd41670
`define FHS_PRECOMP_SLOW_PS 17'd125000
`endif

// *** rtl/fhs_pkg.sv ***
package fhs_pkg;
  typedef enum logic [2:0] {
    FHS_IDLE,
    FHS_CMD,
    FHS_EXEC_RD,
    FHS_EXEC_WR,
    FHS_RESULT
  } fhs_phase_t;
endpackage

// *** rtl/fhs_port.sv ***
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "fhs_regs.svh"
module fhs_port
  import fhs_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic [11:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_media_changed_n,
  input wire logic i_alternate_layout_mode,
  input wire logic i_engine_seeking,
  input wire logic i_engine_no_result,
  input wire logic i_engine_exec_rd,
  input wire logic i_engine_exec_wr,
  input wire logic i_engine_done,
  input wire logic i_engine_overrun,
  input wire logic i_disk_byte_valid,
  input wire logic [7:0] i_disk_byte,
  input wire logic i_disk_byte_take,
  output logic [7:0] o_disk_byte,
  output logic o_ctrl_reset,
  output logic o_cmd_byte_valid,
  output logic [7:0] o_cmd_byte,
  output logic o_density_select_out,
  output logic [1:0] o_rate_code_out,
  output logic [1:0] o_drive_density_pins,
  // 125 ns in picoseconds needs seventeen bits
  output logic [16:0] o_precomp_ps,
  output logic o_fifo_overrun,
  output logic o_zero_fill
);
  localparam int AW = $clog2(FIFO_DEPTH);
  logic [7:0] rate_sel_q;
  logic [7:0] shadow_q;
  logic [1:0] force_q;
  logic [5:0] ctrl_q;
  logic chg_s1_q, chg_s2_q;
  logic alt_s1_q, alt_s2_q;
  fhs_phase_t phase_q;
  logic [7:0] mem_q [FIFO_DEPTH];
  logic [AW:0] cnt_q;
  logic [AW-1:0] wp_q, rp_q;
  logic soft_rst;
  logic wr_rsel, wr_data, rd_data;
  logic fifo_on, fifo_full, fifo_empty;
  logic [1:0] code, kind, rtype;
  logic dens, host_rd_dir, req;
  logic [7:0] status, input_reg;
  logic push, pop;

  assign wr_rsel = i_wr && i_addr == `FHS_ADDR_RATE_SEL;
  assign wr_data = i_wr && i_addr == `FHS_ADDR_DATA;
  assign rd_data = i_rd && i_addr == `FHS_ADDR_DATA;
  assign soft_rst = wr_rsel && i_wdata[`FHS_RATE_SEL_SWRST_BIT];
  assign code = rate_sel_q[1:0];
  assign kind = ctrl_q[`FHS_CTRL_KIND_LSB +: 2];
  assign rtype = ctrl_q[`FHS_CTRL_RTYPE_LSB +: 2];
  assign fifo_on = ctrl_q[`FHS_CTRL_FIFO_EN_BIT];
  assign fifo_full = cnt_q == (AW+1)'(FIFO_DEPTH);
  assign fifo_empty = cnt_q == '0;

  // pins cross from drive cable and strap, two stages each
  always_ff @(posedge i_sys_clk) begin
    chg_s1_q <= i_media_changed_n;
    chg_s2_q <= chg_s1_q;
    alt_s1_q <= i_alternate_layout_mode;
    alt_s2_q <= alt_s1_q;
  end

  // bit 7 is self-clearing: only ever stored as zero
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      rate_sel_q <= `FHS_RATE_SEL_RESET;
    end else if (wr_rsel) begin
      rate_sel_q <= {1'b0, i_wdata[6:0]};
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      shadow_q <= `FHS_RATE_SEL_RESET;
    end else if (wr_rsel) begin
      shadow_q <= i_wdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      force_q <= 2'h0;
    end else if (i_wr && i_addr == `FHS_ADDR_FORCE_CHG) begin
      force_q <= i_wdata[1:0];
    end
  end

  // fifo enable cleared by any reset, set by configure through ctrl
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      ctrl_q <= 6'h00;
    end else if (i_wr && i_addr == `FHS_ADDR_CTRL) begin
      ctrl_q <= i_wdata[5:0];
    end else if (soft_rst) begin
      ctrl_q[`FHS_CTRL_FIFO_EN_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_ctrl_reset <= 1'b0;
    end else begin
      o_ctrl_reset <= soft_rst;
    end
  end

  // command phase tracking
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n || soft_rst) begin
      phase_q <= FHS_IDLE;
    end else begin
      unique case (phase_q)
        FHS_IDLE: if (wr_data) phase_q <= FHS_CMD;
        FHS_CMD: begin
          if (i_engine_no_result) phase_q <= FHS_IDLE;
          else if (i_engine_exec_rd) phase_q <= FHS_EXEC_RD;
          else if (i_engine_exec_wr) phase_q <= FHS_EXEC_WR;
          else if (i_engine_done) phase_q <= FHS_RESULT;
        end
        FHS_EXEC_RD: begin
          // drain before results, even after overrun
          if ((i_engine_done || i_engine_overrun) && fifo_empty) phase_q <= FHS_RESULT;
        end
        FHS_EXEC_WR: if (i_engine_done || i_engine_overrun) phase_q <= FHS_RESULT;
        FHS_RESULT: if (i_engine_done) phase_q <= FHS_IDLE;
      endcase
    end
  end

  // fifo: disk bytes in on read, host bytes in on write
  always_comb begin
    push = 1'b0;
    pop = 1'b0;
    if (phase_q == FHS_EXEC_RD) begin
      push = i_disk_byte_valid && !fifo_full;
      pop = rd_data && !fifo_empty;
    end else if (phase_q == FHS_EXEC_WR) begin
      push = wr_data && !fifo_full;
      pop = i_disk_byte_take && !fifo_empty;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_q[wp_q] <= (phase_q == FHS_EXEC_RD) ? i_disk_byte : i_wdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n || soft_rst || (phase_q == FHS_CMD && (i_engine_exec_rd || i_engine_exec_wr))) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= AW'((wp_q + 1'b1) % FIFO_DEPTH);
      if (pop) rp_q <= AW'((rp_q + 1'b1) % FIFO_DEPTH);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_fifo_overrun <= 1'b0;
      o_zero_fill <= 1'b0;
      o_disk_byte <= 8'h00;
    end else begin
      o_fifo_overrun <= (phase_q == FHS_EXEC_RD && i_disk_byte_valid && fifo_full) ||
                        (phase_q == FHS_EXEC_WR && i_disk_byte_take && fifo_empty);
      o_zero_fill <= phase_q == FHS_EXEC_WR && i_engine_overrun;
      o_disk_byte <= (pop && phase_q == FHS_EXEC_WR) ? mem_q[rp_q] : 8'h00;
    end
  end

  // parameters go to the engine byte by byte, never buffered
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_cmd_byte_valid <= 1'b0;
      o_cmd_byte <= 8'h00;
    end else begin
      o_cmd_byte_valid <= wr_data && (phase_q == FHS_IDLE || phase_q == FHS_CMD);
      o_cmd_byte <= i_wdata;
    end
  end

  // rate decode
  always_comb begin
    dens = code == 2'b11 || code == 2'b00;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_density_select_out <= 1'b1;
      o_rate_code_out <= 2'b10;
      o_drive_density_pins <= 2'b00;
      o_precomp_ps <= `FHS_PRECOMP_SLOW_PS;
    end else begin
      o_density_select_out <= dens;
      o_rate_code_out <= code;
      unique case (kind)
        2'b00: o_drive_density_pins <= {code[0], dens};
        2'b10: o_drive_density_pins <= {code[0], code[1]};
        2'b01: o_drive_density_pins <= {code[0], !dens};
        2'b11: o_drive_density_pins <= {code[1], code[0]};
      endcase
      // only the default setting is modelled; others need the precomp table
      if (rate_sel_q[`FHS_RATE_SEL_PRECOMP_LSB +: 3] == 3'b000) begin
        if (code == 2'b01 && rtype == 2'b10) o_precomp_ps <= `FHS_PRECOMP_2M_PS;
        else if (code == 2'b11) o_precomp_ps <= `FHS_PRECOMP_1M_PS;
        else o_precomp_ps <= `FHS_PRECOMP_SLOW_PS;
      end
    end
  end

  always_comb begin
    req = 1'b0;
    host_rd_dir = 1'b0;
    unique case (phase_q)
      FHS_IDLE, FHS_CMD: req = 1'b1;
      FHS_EXEC_RD: begin
        req = !fifo_empty && (!fifo_on || 1'b1);
        host_rd_dir = 1'b1;
      end
      FHS_EXEC_WR: req = !fifo_full;
      FHS_RESULT: begin
        req = 1'b1;
        host_rd_dir = 1'b1;
      end
    endcase
    status = 8'h00;
    status[`FHS_ST_REQ_BIT] = req;
    status[`FHS_ST_DIR_BIT] = host_rd_dir;
    status[`FHS_ST_BUSY_BIT] = phase_q != FHS_IDLE;
    status[`FHS_ST_SEEK_BIT] = i_engine_seeking;
  end

  always_comb begin
    input_reg = 8'h00;
    input_reg[7] = force_q[`FHS_FORCE_EN_BIT] ? force_q[`FHS_FORCE_VAL_BIT] : !chg_s2_q;
    if (alt_s2_q) begin
      input_reg[6:3] = 4'hf;
      input_reg[2:1] = code;
      input_reg[0] = !(code == 2'b00 || code == 2'b11);
    end
  end

  // status is combinational into the read latch, so no wait after a transfer
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      unique case (i_addr)
        `FHS_ADDR_STATUS: o_rdata <= status;
        `FHS_ADDR_DATA: o_rdata <= (phase_q == FHS_EXEC_RD) ? mem_q[rp_q] : 8'h00;
        `FHS_ADDR_INPUT: o_rdata <= input_reg;
        `FHS_ADDR_RATE_SHADOW: o_rdata <= shadow_q;
        `FHS_ADDR_FORCE_CHG: o_rdata <= {6'h00, force_q};
        `FHS_ADDR_CTRL: o_rdata <= {2'b00, ctrl_q};
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// *** tb/fhs_port_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fhs_regs.svh"
module fhs_port_assertions (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic [11:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_alternate_layout_mode,
  input wire logic i_engine_seeking,
  input wire logic o_ctrl_reset,
  input wire logic o_cmd_byte_valid,
  input wire logic [7:0] o_cmd_byte,
  input wire logic [1:0] o_rate_code_out,
  input wire logic [16:0] o_precomp_ps
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_rd_st;
    i_rd && i_addr == `FHS_ADDR_STATUS;
  endsequence
  sequence s_rd_in;
    i_rd && i_addr == `FHS_ADDR_INPUT;
  endsequence
  sequence s_swrst;
    i_wr && i_addr == `FHS_ADDR_RATE_SEL && i_wdata[7] ##1 o_ctrl_reset;
  endsequence
  AST_RD_IDLE: assert property (!i_rd |=> o_rdata == 8'h00) else $error("read data not idle");
  AST_SWRST: assert property (i_wr && i_addr == `FHS_ADDR_RATE_SEL && i_wdata[7] |=> o_ctrl_reset)
    else $error("soft reset missing");
  AST_SWRST_CLEAR: assert property (s_swrst |=> !o_ctrl_reset) else $error("soft reset stuck");
  AST_ST_ZERO: assert property (s_rd_st |=> o_rdata[5] == 1'b0 && o_rdata[3:1] == 3'h0)
    else $error("status zero bits set");
  AST_SEEK: assert property (s_rd_st |=> o_rdata[0] == $past(i_engine_seeking))
    else $error("seek flag wrong");
  AST_IN_LEGACY: assert property (!i_alternate_layout_mode [*4] ##0 s_rd_in |=> o_rdata[6:0] == 7'h00)
    else $error("legacy input bits set");
  AST_IN_ALT: assert property (i_alternate_layout_mode [*4] ##0 s_rd_in |=>
    o_rdata[6:1] == {4'hf, $past(o_rate_code_out)}) else $error("alternate input bits wrong");
  AST_CMD: assert property (o_cmd_byte_valid |-> $past(i_wr) && $past(i_addr) == `FHS_ADDR_DATA
    && o_cmd_byte == $past(i_wdata)) else $error("command byte wrong");
  AST_PRECOMP: assert property (o_rate_code_out != 2'b01 |-> o_precomp_ps ==
    (o_rate_code_out == 2'b11 ? `FHS_PRECOMP_1M_PS : `FHS_PRECOMP_SLOW_PS)) else $error("precomp wrong");
endmodule
bind fhs_port fhs_port_assertions fhs_port_assertions_inst (.i_sys_clk, .i_reset_n, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .i_alternate_layout_mode, .i_engine_seeking, .o_ctrl_reset, .o_cmd_byte_valid,
  .o_cmd_byte, .o_rate_code_out, .o_precomp_ps);
`default_nettype wire

// *** tb/fhs_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fhs_host_model (
  input wire logic i_sys_clk,
  input wire logic [7:0] i_rdata,
  output logic [11:0] o_addr = 12'h000,
  output logic [7:0] o_wdata = 8'h00,
  output logic o_wr = 1'b0,
  output logic o_rd = 1'b0
);
  // released bus shows inverted values, never the last ones
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_sys_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_sys_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    @(posedge i_sys_clk);
    d = i_rdata;
  endtask
  // every data byte waits for the request flag, for at most 50 status reads
  task automatic poll;
    logic [7:0] s;
    s = 8'h00;
    for (int n = 0; n < 50 && !s[7]; n++) rd(12'h3f4, s);
  endtask
  task automatic put(input logic [7:0] d);
    poll;
    wr(12'h3f5, d);
  endtask
  task automatic get(output logic [7:0] d);
    poll;
    rd(12'h3f5, d);
  endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fhs_regs.svh"
module testbench;
  logic i_sys_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_alternate_layout_mode = 1'b0;
  logic i_media_changed_n = 1'b1;
  logic i_engine_seeking = 1'b0;
  logic i_disk_byte_valid = 1'b0;
  logic [7:0] i_disk_byte = 8'h00;
  logic [4:0] eng = 5'h00;
  logic [11:0] i_addr;
  logic [7:0] i_wdata, o_rdata;
  logic i_wr, i_rd, o_density_select_out, o_zero_fill;
  logic [1:0] o_rate_code_out, o_drive_density_pins;
  logic [16:0] o_precomp_ps;
  int n_errors = 0;
  int comparisons = 0;
  always #12.5 i_sys_clk = ~i_sys_clk;
  fhs_host_model fhs_host_model_inst (.i_sys_clk, .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata),
    .o_wr(i_wr), .o_rd(i_rd));
  fhs_port fhs_port_inst (.i_sys_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_media_changed_n, .i_alternate_layout_mode, .i_engine_seeking, .i_engine_no_result(eng[0]),
    .i_engine_exec_rd(eng[1]), .i_engine_exec_wr(eng[2]), .i_engine_done(eng[3]), .i_engine_overrun(eng[4]),
    .i_disk_byte_valid, .i_disk_byte, .i_disk_byte_take(1'b0), .o_disk_byte(), .o_ctrl_reset(),
    .o_cmd_byte_valid(), .o_cmd_byte(), .o_density_select_out, .o_rate_code_out, .o_drive_density_pins,
    .o_precomp_ps, .o_fifo_overrun(), .o_zero_fill);
  task automatic chk(input logic [16:0] g, input logic [16:0] e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic w(input logic [11:0] a, input logic [7:0] d);
    fhs_host_model_inst.wr(a, d);
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] d;
    fhs_host_model_inst.rd(a, d);
    chk(d, e);
  endtask
  task automatic pulse(input int b);
    @(posedge i_sys_clk);
    eng <= 5'(1 << b);
    @(posedge i_sys_clk);
    eng <= 5'h00;
  endtask
  task automatic t_reset;
    rc(12'h01f, 8'h02);
    rc(12'h3f7, 8'h00);
    rc(12'h100, 8'h00);
    chk(o_rate_code_out, 2'b10);
    chk(o_precomp_ps, `FHS_PRECOMP_SLOW_PS);
    $display("reset test done");
  endtask
  task automatic t_rates;
    logic d;
    logic [1:0] p;
    for (int t = 0; t < 3; t++)
      for (int k = 0; k < 4; k++)
        for (int c = 0; c < 4; c++) begin
          w(12'h020, 8'(t * 8 + k * 2));
          w(12'h3f4, 8'(c));
          repeat (3) @(posedge i_sys_clk);
          d = c == 0 || c == 3;
          p = k == 0 ? {c[0], d} : k == 2 ? {c[0], c[1]} : k == 1 ? {c[0], !d} : {c[1], c[0]};
          chk(o_rate_code_out, 16'(c));
          chk(o_density_select_out, d);
          chk(o_drive_density_pins, p);
          chk(o_precomp_ps, c == 3 ? `FHS_PRECOMP_1M_PS : (c == 1 && t == 2) ? `FHS_PRECOMP_2M_PS :
            `FHS_PRECOMP_SLOW_PS);
          rc(12'h01f, 8'(c));
        end
    $display("rate table test done");
  endtask
  task automatic t_resets;
    w(12'h3f4, 8'h01);
    w(12'h3f4, 8'h81);
    repeat (3) @(posedge i_sys_clk);
    chk(o_rate_code_out, 2'b01);
    i_reset_n <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    @(posedge i_sys_clk);
    chk(o_rate_code_out, 2'b10);
    rc(12'h01f, 8'h02);
    $display("reset kinds test done");
  endtask
  task automatic t_input;
    i_alternate_layout_mode <= 1'b1;
    repeat (5) @(posedge i_sys_clk);
    rc(12'h3f7, 8'h7d);
    w(12'h01e, 8'h03);
    rc(12'h3f7, 8'hfd);
    w(12'h01e, 8'h00);
    i_media_changed_n <= 1'b0;
    repeat (5) @(posedge i_sys_clk);
    rc(12'h3f7, 8'hfd);
    i_alternate_layout_mode <= 1'b0;
    repeat (5) @(posedge i_sys_clk);
    rc(12'h3f7, 8'h80);
    i_media_changed_n <= 1'b1;
    $display("input register test done");
  endtask
  task automatic t_phases;
    logic [7:0] d;
    int hit;
    hit = 0;
    i_engine_seeking <= 1'b1;
    rc(12'h3f4, 8'h81);
    fhs_host_model_inst.put(8'h0f);
    rc(12'h3f4, 8'h91);
    pulse(0);
    i_engine_seeking <= 1'b0;
    rc(12'h3f4, 8'h80);
    fhs_host_model_inst.put(8'h46);
    pulse(1);
    i_disk_byte_valid <= 1'b1;
    i_disk_byte <= 8'ha5;
    @(posedge i_sys_clk);
    i_disk_byte_valid <= 1'b0;
    i_disk_byte <= 8'h5a;
    pulse(4);
    rc(12'h3f4, 8'hd0);
    fhs_host_model_inst.get(d);
    chk(d, 8'ha5);
    pulse(3);
    rc(12'h3f4, 8'hd0);
    pulse(3);
    rc(12'h3f4, 8'h80);
    fhs_host_model_inst.put(8'h45);
    pulse(2);
    rc(12'h3f4, 8'h90);
    pulse(4);
    repeat (6) @(posedge i_sys_clk) if (o_zero_fill === 1'b1) hit++;
    chk(16'(hit), 16'h1);
    $display("phase test done");
  endtask
  task automatic complete_run;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    @(posedge i_sys_clk);
    t_reset;
    t_rates;
    t_resets;
    t_input;
    t_phases;
    complete_run;
  end
  // whole sequence needs about six hundred cycles
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    n_errors++;
    complete_run;
  end
endmodule
`default_nettype wire
